//--- src/conv_ctrl.sv
// The implementer's own choices: the strobed register port and the register addresses.
`timescale 1ns/100ps
module conv_ctrl
    import conv_ctrl_pkg::*;
(
    input  wire logic         i_clk,
    input  wire logic         i_rst,
    input  wire logic         i_scl,
    input  wire logic         i_sda,
    output logic              o_sda,
    output logic              o_sda_oe_n,
    input  wire logic [2:0]   i_hw_addr,
    input  wire logic         i_comp,
    input  wire logic         i_clock_source_select,
    input  wire logic         i_clock_pin_io,
    output logic              o_clock_pin_io,
    output logic              o_clock_pin_io_oe_n,
    output logic [255:0]      o_tap_sel,
    output logic              o_buf_en,
    output logic              o_hold,
    output logic              o_sample,
    output logic [1:0]        o_channel,
    output logic [1:0]        o_in_mode,
    input  wire reg_req_t     i_req,
    output logic [7:0]        o_rdata
);

    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_ADDR = 3'b001,
        S_AACK = 3'b010,
        S_WR   = 3'b011,
        S_WACK = 3'b100,
        S_RD   = 3'b101,
        S_RACK = 3'b110
    } bus_st_t;

    typedef enum logic [1:0] {
        C_IDLE  = 2'b00,
        C_TRIAL = 2'b01,
        C_DONE  = 2'b10
    } conv_st_t;

    // Highest channel per input mode
    function automatic logic [1:0] top_ch(input logic [1:0] m);
        top_ch = (m == 2'd0) ? 2'd3 : (m == 2'd3) ? 2'd1 : 2'd2;
    endfunction

    function automatic logic [1:0] clamp_ch(input logic [1:0] c,
                                           input logic [1:0] m);
        clamp_ch = (c > top_ch(m)) ? top_ch(m) : c;
    endfunction

    function automatic logic is_diff(input logic [1:0] c,
                                     input logic [1:0] m);
        is_diff = (m == 2'd1) || (m == 2'd3) ||
                  ((m == 2'd2) && (c == 2'd2));
    endfunction

    // Input synchronisers
    logic [1:0] scl_s_q;
    logic [1:0] sda_s_q;
    logic [1:0] comp_s_q;
    logic [1:0] ext_s_q;
    logic [1:0] cpin_s_q;
    logic [2:0] hwa_m_q;
    logic [2:0] hwa_q;
    logic       scl_p_q;
    logic       sda_p_q;
    logic       cpin_p_q;

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            scl_s_q  <= 2'b11;
            sda_s_q  <= 2'b11;
            comp_s_q <= 2'b00;
            ext_s_q  <= 2'b00;
            cpin_s_q <= 2'b00;
            hwa_m_q  <= 3'h0;
            hwa_q    <= 3'h0;
            scl_p_q  <= 1'b1;
            sda_p_q  <= 1'b1;
            cpin_p_q <= 1'b0;
        end
        else
        begin
            scl_s_q  <= {scl_s_q[0], i_scl};
            sda_s_q  <= {sda_s_q[0], i_sda};
            comp_s_q <= {comp_s_q[0], i_comp};
            ext_s_q  <= {ext_s_q[0], i_clock_source_select};
            cpin_s_q <= {cpin_s_q[0], i_clock_pin_io};
            hwa_m_q  <= i_hw_addr;
            hwa_q    <= hwa_m_q;
            scl_p_q  <= scl_s_q[1];
            sda_p_q  <= sda_s_q[1];
            cpin_p_q <= cpin_s_q[1];
        end
    end

    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start_c;
    logic stop_c;
    assign scl      = scl_s_q[1];
    assign sda      = sda_s_q[1];
    assign scl_rise = scl & ~scl_p_q;
    assign scl_fall = ~scl & scl_p_q;
    assign start_c  = scl & scl_p_q & sda_p_q & ~sda;
    assign stop_c   = scl & scl_p_q & ~sda_p_q & sda;

    // Bus slave
    bus_st_t    st_q;
    logic [3:0] cnt_q;
    logic [7:0] sh_q;
    logic [7:0] tx_q;
    logic       drv_low_q;
    logic       rw_q;
    logic       wr_first_q;
    logic       macked_q;
    logic       trig;
    ctrl_byte_t ctrl_q;
    logic [7:0] dac_q;
    logic [7:0] adc_q;
    logic [1:0] ch_q;
    logic [7:0] div_q;
    conv_st_t   cst_q;
    logic [7:0] sar_q;
    logic [7:0] bit_q;
    logic       tick;
    logic       osc_q;
    logic       osc_rise;

    assign trig = scl_fall &
                  (((st_q == S_AACK) & rw_q) |
                   ((st_q == S_RACK) & macked_q));

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            st_q       <= S_IDLE;
            cnt_q      <= 4'h0;
            sh_q       <= 8'h00;
            tx_q       <= 8'h00;
            drv_low_q  <= 1'b0;
            rw_q       <= 1'b0;
            wr_first_q <= 1'b0;
            macked_q   <= 1'b0;
        end
        else if (start_c)
        begin
            st_q      <= S_ADDR;
            cnt_q     <= 4'h0;
            drv_low_q <= 1'b0;
        end
        else if (stop_c)
        begin
            st_q      <= S_IDLE;
            drv_low_q <= 1'b0;
        end
        else if (scl_rise)
        begin
            unique case (st_q)
                S_ADDR, S_WR:
                begin
                    sh_q  <= {sh_q[6:0], sda};
                    cnt_q <= cnt_q + 4'h1;
                end
                S_RD:
                    cnt_q <= cnt_q + 4'h1;
                S_RACK:
                    macked_q <= ~sda;
                default:
                    cnt_q <= cnt_q;
            endcase
        end
        else if (scl_fall)
        begin
            unique case (st_q)
                S_ADDR:
                    if (cnt_q == BITS_PER_BYTE)
                    begin
                        if (sh_q[7:1] == {ADDR_FIXED, hwa_q})
                        begin
                            st_q      <= S_AACK;
                            drv_low_q <= 1'b1;
                            rw_q      <= sh_q[0];
                        end
                        else
                            st_q <= S_IDLE;
                    end
                S_AACK:
                begin
                    cnt_q <= 4'h0;
                    if (rw_q)
                    begin
                        st_q      <= S_RD;
                        tx_q      <= {adc_q[6:0], 1'b1};
                        drv_low_q <= ~adc_q[7];
                    end
                    else
                    begin
                        st_q       <= S_WR;
                        wr_first_q <= 1'b1;
                        drv_low_q  <= 1'b0;
                    end
                end
                S_WR:
                    if (cnt_q == BITS_PER_BYTE)
                    begin
                        st_q      <= S_WACK;
                        drv_low_q <= 1'b1;
                    end
                S_WACK:
                begin
                    st_q       <= S_WR;
                    cnt_q      <= 4'h0;
                    wr_first_q <= 1'b0;
                    drv_low_q  <= 1'b0;
                end
                S_RD:
                    if (cnt_q == BITS_PER_BYTE)
                    begin
                        st_q      <= S_RACK;
                        drv_low_q <= 1'b0;
                    end
                    else
                    begin
                        drv_low_q <= ~tx_q[7];
                        tx_q      <= {tx_q[6:0], 1'b1};
                    end
                S_RACK:
                begin
                    cnt_q <= 4'h0;
                    if (macked_q)
                    begin
                        st_q      <= S_RD;
                        tx_q      <= {adc_q[6:0], 1'b1};
                        drv_low_q <= ~adc_q[7];
                    end
                    else
                        st_q <= S_IDLE;
                end
                default:
                    st_q <= S_IDLE;
            endcase
        end
    end

    assign o_sda      = 1'b0;
    assign o_sda_oe_n = ~drv_low_q;

    // Control and DAC code from write bytes
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            ctrl_q <= ctrl_byte_t'(CTRL_RST);
            dac_q  <= DAC_RST;
        end
        else if (scl_fall && st_q == S_WR && cnt_q == BITS_PER_BYTE)
        begin
            if (wr_first_q)
                ctrl_q <= ctrl_byte_t'(sh_q);
            else
                dac_q <= sh_q;
        end
    end

    // Conversion clock source
    logic [7:0] dcnt_q;
    logic       osc_run;
    assign osc_run  = ctrl_q.out_en | (cst_q != C_IDLE);

    always_ff @(posedge i_clk)
    begin
        if (i_rst || !osc_run)
        begin
            dcnt_q <= 8'h00;
            osc_q  <= 1'b0;
        end
        else if (dcnt_q >= div_q)
        begin
            dcnt_q <= 8'h00;
            osc_q  <= ~osc_q;
        end
        else
            dcnt_q <= dcnt_q + 8'h01;
    end

    assign osc_rise = osc_run && dcnt_q >= div_q && !osc_q;
    assign tick     = ext_s_q[1] ? (cpin_s_q[1] & ~cpin_p_q)
                                 : osc_rise;
    assign o_clock_pin_io      = osc_q;
    assign o_clock_pin_io_oe_n = ext_s_q[1];

    // Successive approximation
    logic [1:0] chsel;
    logic [2:0] settle_q;
    logic       tick_ok;
    assign chsel = clamp_ch(ch_q, ctrl_q.in_mode);
    // Comparator sees a new trial only after tap and synchroniser
    assign tick_ok = tick && (settle_q == SETTLE_CYC);

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            cst_q <= C_IDLE;
            sar_q <= 8'h00;
            bit_q <= 8'h00;
            adc_q <= ADC_RST;
            ch_q  <= 2'd0;
            settle_q <= 3'h0;
        end
        else
        begin
            if (settle_q != SETTLE_CYC)
                settle_q <= settle_q + 3'h1;
            if (scl_fall && st_q == S_WR && cnt_q == BITS_PER_BYTE
                && wr_first_q)
                ch_q <= sh_q[1:0];
            unique case (cst_q)
                C_IDLE:
                    if (trig)
                    begin
                        cst_q <= C_TRIAL;
                        sar_q <= SAR_MSB;
                        bit_q <= SAR_MSB;
                        settle_q <= 3'h0;
                    end
                C_TRIAL:
                    if (tick_ok)
                    begin
                        settle_q <= 3'h0;
                        // Keep bit when input above trial level
                        sar_q <= (comp_s_q[1] ? sar_q : sar_q & ~bit_q)
                                 | (bit_q >> 1);
                        bit_q <= bit_q >> 1;
                        if (bit_q == 8'h01)
                            cst_q <= C_DONE;
                    end
                C_DONE:
                begin
                    cst_q <= C_IDLE;
                    adc_q <= is_diff(chsel, ctrl_q.in_mode)
                             ? sar_q ^ SAR_MSB : sar_q;
                    if (ctrl_q.auto_inc)
                        ch_q <= (chsel == top_ch(ctrl_q.in_mode))
                                ? 2'd0 : chsel + 2'd1;
                    else
                        ch_q <= chsel;
                end
                default:
                    cst_q <= C_IDLE;
            endcase
        end
    end

    // DAC tap decode, shared with conversion
    logic [7:0] tap_code;
    assign tap_code = (cst_q == C_IDLE) ? dac_q : sar_q;

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            o_tap_sel <= '0;
        else
            o_tap_sel <= 256'(1) << tap_code;
    end

    assign o_hold    = cst_q != C_IDLE;
    assign o_sample  = trig;
    assign o_buf_en  = ctrl_q.out_en;
    assign o_channel = chsel;
    assign o_in_mode = ctrl_q.in_mode;

    // Register port
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            div_q <= DIV_RST;
        else if (i_req.wr && i_req.addr == OFS_DIV)
            div_q <= i_req.wdata;
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            o_rdata <= 8'h00;
        else if (i_req.rd)
        begin
            unique case (i_req.addr)
                OFS_CTRL:   o_rdata <= ctrl_q;
                OFS_DAC:    o_rdata <= dac_q;
                OFS_ADC:    o_rdata <= adc_q;
                OFS_STATUS: o_rdata <= {4'h0, st_q == S_IDLE,
                                        o_hold, chsel};
                OFS_DIV:    o_rdata <= div_q;
                default:    o_rdata <= 8'h00;
            endcase
        end
        else
            o_rdata <= 8'h00;
    end
endmodule

//--- src/conv_ctrl_pkg.sv
package conv_ctrl_pkg;

    typedef struct packed {
        logic       rsvd_hi;
        logic       out_en;
        logic [1:0] in_mode;
        logic       rsvd_lo;
        logic       auto_inc;
        logic [1:0] channel;
    } ctrl_byte_t;

    typedef struct packed {
        logic [2:0] addr;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } reg_req_t;

    localparam logic [7:0] CTRL_RST      = 8'h00;
    localparam logic [7:0] DAC_RST       = 8'h00;
    localparam logic [7:0] ADC_RST       = 8'h80;
    localparam logic [7:0] SAR_MSB       = 8'h80;
    localparam logic [3:0] ADDR_FIXED    = 4'h9;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    localparam logic [2:0] OFS_CTRL   = 3'h0;
    localparam logic [2:0] OFS_DAC    = 3'h1;
    localparam logic [2:0] OFS_ADC    = 3'h2;
    localparam logic [2:0] OFS_STATUS = 3'h3;
    localparam logic [2:0] OFS_DIV    = 3'h4;

    localparam logic [7:0] DIV_RST = 8'h04;
    localparam logic [2:0] SETTLE_CYC = 3'h4;
    localparam int unsigned CLK_MHZ = 250;
endpackage

//--- test/i2c_master_model.sv
`timescale 1ns/100ps
module i2c_master_model #(
    parameter int Q = 5
) (
    input  wire logic  i_clk,
    input  wire logic  i_sda,
    output logic       o_scl,
    output logic       o_sda_oe_n,
    output logic       o_got,
    output logic [7:0] o_byte
);
    initial
    begin
        o_scl = 1'b1;
        o_sda_oe_n = 1'b1;
        o_got = 1'b0;
        o_byte = 8'h00;
    end

    task automatic wq();
        repeat (Q) @(posedge i_clk);
    endtask

    // Also a repeated start
    task automatic start();
        wq();
        o_sda_oe_n <= 1'b1;
        wq();
        o_scl <= 1'b1;
        wq();
        o_sda_oe_n <= 1'b0;
        wq();
        o_scl <= 1'b0;
    endtask

    task automatic stop();
        wq();
        o_sda_oe_n <= 1'b0;
        wq();
        o_scl <= 1'b1;
        wq();
        o_sda_oe_n <= 1'b1;
        wq();
    endtask

    task automatic bit_io(input logic b, output logic r);
        wq();
        o_sda_oe_n <= b;
        wq();
        o_scl <= 1'b1;
        wq();
        r = i_sda;
        wq();
        o_scl <= 1'b0;
    endtask

    task automatic put_byte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(b[i], r);
        bit_io(1'b1, r);
        ack = ~r;
    endtask

    task automatic get_byte(input logic ack_it, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            bit_io(1'b1, r);
            b[i] = r;
        end
        o_byte <= b;
        o_got <= 1'b1;
        @(posedge i_clk);
        o_got <= 1'b0;
        bit_io(~ack_it, r);
    endtask
endmodule

//--- test/conv_ctrl_sva.sv
`timescale 1ns/100ps
module conv_ctrl_sva (
    input wire logic         i_clk,
    input wire logic         i_rst,
    input wire logic         i_scl,
    input wire logic         o_sda_oe_n,
    input wire logic         i_clock_source_select,
    input wire logic         o_clock_pin_io_oe_n,
    input wire logic [255:0] o_tap_sel,
    input wire logic         o_buf_en,
    input wire logic         o_hold,
    input wire logic         o_sample
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);

    a_tap_one_hot:
        assert property (!$past(i_rst) |-> $onehot(o_tap_sel))
        else $error("tap select not one-hot");
    a_reset_clear:
        assert property ($past(i_rst) |-> !o_buf_en && !o_hold && o_sda_oe_n)
        else $error("outputs not cleared by reset");
    a_hold_ends:
        assert property ($rose(o_hold) |-> ##[1:400] !o_hold)
        else $error("conversion hold too long");
    a_sample_hold:
        assert property (o_sample |-> ##[0:2] o_hold)
        else $error("sample without hold");
    a_sample_pulse:
        assert property (o_sample |=> !o_sample)
        else $error("sample pulse too long");
    a_sda_stable:
        assert property (i_scl && $past(i_scl, 4) |-> $stable(o_sda_oe_n))
        else $error("data changed while clock high");
    a_ack_in_low:
        assert property ($fell(o_sda_oe_n) |-> !i_scl)
        else $error("data pulled low while clock high");
    a_osc_internal:
        assert property (!i_clock_source_select [*6] |-> !o_clock_pin_io_oe_n)
        else $error("clock pin not driven");
    a_osc_external:
        assert property (i_clock_source_select [*6] |-> o_clock_pin_io_oe_n)
        else $error("clock pin not released");
endmodule

//--- test/conv_ctrl_tb.sv
`timescale 1ns/100ps
module conv_ctrl_tb;
    import conv_ctrl_pkg::*;

    logic         clk;
    logic         rst;
    logic         scl;
    logic         m_oe_n;
    wire logic    sda;
    logic [2:0]   hw_addr;
    logic         comp;
    logic         sel;
    logic [2:0]   ext_div;
    reg_req_t     req;
    logic         rd_d;
    logic         got;
    logic [7:0]   got_byte;
    logic         dev_sda;
    logic         dev_oe_n;
    logic         osc_oe_n;
    logic         osc_pin;
    logic         osc_prev;
    int           osc_edges;
    logic [255:0] tap;
    logic         buf_en;
    logic [1:0]   chan;
    logic [1:0]   mode_o;
    logic [7:0]   rdata;
    logic [7:0]   tap_idx;
    logic [7:0]   vin [4];
    logic [7:0]   exp_q [$];
    logic [7:0]   last;
    logic [7:0]   code;
    logic [1:0]   ch;
    logic [1:0]   mode;
    logic         ai;
    logic         ack;
    int           err_total;
    int           num_checks;
    int           cyc;

    always #2 clk = ~clk;
    always @(posedge clk) ext_div <= ext_div + 3'h1;
    assign sda = m_oe_n & (dev_oe_n | dev_sda);

    // Comparator: channel level against the selected tap
    always_comb
    begin
        tap_idx = 8'h00;
        for (int k = 0; k < 256; k++)
            if (tap[k])
                tap_idx = 8'(k);
    end
    assign comp = (vin[chan] >= tap_idx);

    i2c_master_model m (.i_clk(clk), .i_sda(sda), .o_scl(scl),
        .o_sda_oe_n(m_oe_n), .o_got(got), .o_byte(got_byte));

    conv_ctrl uut (.i_clk(clk), .i_rst(rst), .i_scl(scl), .i_sda(sda),
        .o_sda(dev_sda), .o_sda_oe_n(dev_oe_n), .i_hw_addr(hw_addr),
        .i_comp(comp), .i_clock_source_select(sel),
        .i_clock_pin_io(ext_div[2]), .o_clock_pin_io(osc_pin),
        .o_clock_pin_io_oe_n(osc_oe_n), .o_tap_sel(tap),
        .o_buf_en(buf_en), .o_hold(), .o_sample(), .o_channel(chan),
        .o_in_mode(mode_o), .i_req(req), .o_rdata(rdata));

    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        num_checks++;
        if (g !== e)
        begin
            err_total++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask

    task automatic results();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Read: d is the expected data
    task automatic reg_op(input logic w, input logic [2:0] a,
                          input logic [7:0] d);
        req <= '{addr: a, wr: w, rd: ~w, wdata: d};
        if (!w)
            exp_q.push_back(d);
        @(posedge clk);
    endtask

    task automatic wr_xfer(input logic [7:0] c, input logic stp);
        logic [7:0] b [3];
        b = '{{ADDR_FIXED, hw_addr, 1'b0}, c, code};
        m.start();
        for (int i = 0; i < 3; i++)
        begin
            m.put_byte(b[i], ack);
            chk(8'(ack), 8'h01);
        end
        if (stp)
            m.stop();
    endtask

    task automatic rd_xfer(input int n);
        logic [7:0] b;
        m.start();
        m.put_byte({ADDR_FIXED, hw_addr, 1'b1}, ack);
        chk(8'(ack), 8'h01);
        for (int i = 0; i < n; i++)
        begin
            exp_q.push_back(last);
            last = vin[ch] ^ ((mode != 2'h0) ? 8'h80 : 8'h00);
            if (ai)
                ch = ch + 2'h1;
            m.get_byte(i < n - 1, b);
        end
        m.stop();
    endtask

    always @(posedge clk)
    begin
        rd_d <= req.rd;
        cyc <= cyc + 1;
        osc_prev <= osc_pin;
        if (osc_pin !== osc_prev)
            osc_edges = osc_edges + 1;
        if (rd_d)
            chk(rdata, exp_q.pop_front());
        if (got)
            chk(got_byte, exp_q.pop_front());
        if (cyc == 40000)
        begin
            err_total++;
            results();
        end
    end

    initial
    begin
        clk = 1'b0;
        rst = 1'b1;
        req = '0;
        sel = 1'b0;
        ext_div = 3'h0;
        rd_d = 1'b0;
        cyc = 0;
        osc_prev = 1'b0;
        osc_edges = 0;
        err_total = 0;
        num_checks = 0;
        last = ADC_RST;
        ch = 2'h0;
        mode = 2'h0;
        ai = 1'b0;
        void'($urandom(32'h41CA));
        foreach (vin[i])
            vin[i] = 8'($urandom);
        hw_addr = 3'($urandom);
        code = 8'($urandom);
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        reg_op(1'b0, OFS_CTRL, CTRL_RST);
        reg_op(1'b0, OFS_DAC, DAC_RST);
        reg_op(1'b0, OFS_ADC, ADC_RST);
        reg_op(1'b0, OFS_DIV, DIV_RST);
        reg_op(1'b1, OFS_CTRL, 8'hFF);
        reg_op(1'b0, OFS_CTRL, CTRL_RST);
        reg_op(1'b0, 3'h7, 8'h00);
        reg_op(1'b1, OFS_DIV, 8'h03);
        reg_op(1'b0, OFS_DIV, 8'h03);
        req <= '0;
        chk(8'(buf_en), 8'h00);
        wr_xfer(8'h44, 1'b1);
        ai = 1'b1;
        chk(tap_idx, code);
        chk(8'(buf_en), 8'h01);
        code = ~code;
        wr_xfer(8'h44, 1'b0);
        chk(tap_idx, code);
        m.start();
        m.put_byte({ADDR_FIXED, ~hw_addr, 1'b0}, ack);
        chk(8'(ack), 8'h00);
        m.stop();
        chk(tap_idx, code);
        rd_xfer(3);
        rd_xfer(2);
        for (int md = 0; md < 4; md++)
        begin
            wr_xfer({2'b01, 2'(md), 4'h3}, 1'b1);
            chk(8'(mode_o), 8'(md));
            chk(8'(chan),
                (md == 0) ? 8'h03 : (md == 3) ? 8'h01 : 8'h02);
        end
        wr_xfer(8'h50, 1'b1);
        mode = 2'h1;
        ch = 2'h0;
        ai = 1'b0;
        rd_xfer(2);
        sel <= 1'b1;
        repeat (8) @(posedge clk);
        chk(8'(osc_oe_n), 8'h01);
        rd_xfer(1);
        sel <= 1'b0;
        repeat (8) @(posedge clk);
        chk(8'(osc_oe_n), 8'h00);
        rd_xfer(1);
        chk(8'(osc_edges > 0), 8'h01);
        results();
    end
endmodule

bind conv_ctrl conv_ctrl_sva sva_i (.i_clk(i_clk), .i_rst(i_rst),
    .i_scl(i_scl), .o_sda_oe_n(o_sda_oe_n),
    .i_clock_source_select(i_clock_source_select),
    .o_clock_pin_io_oe_n(o_clock_pin_io_oe_n), .o_tap_sel(o_tap_sel),
    .o_buf_en(o_buf_en), .o_hold(o_hold), .o_sample(o_sample));
